// >>> rtl/reset_and_debug_access_control.sv
`timescale 1ns/1ps
`default_nettype none

module reset_and_debug_access_control #(
    parameter logic [31:0] PROT_ONE_PATTERN   = 32'h1111_1111,
    parameter logic [31:0] PROT_TWO_PATTERN   = 32'h2222_2222,
    parameter logic [31:0] PROT_THREE_PATTERN = 32'h3333_3333
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        reset_pin_n,
    input  wire logic        watchdog_reset,
    input  wire logic        power_on_reset,
    input  wire logic [3:0]  bod_irq_below,
    input  wire logic [3:0]  bod_rst_below,
    input  wire logic [31:0] flash_prot_word,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             chip_reset_n,
    output logic             internal_rc_oscillator_en,
    output logic             main_clk_is_irc,
    output logic             flash_ctrl_init,
    output logic             fetch_start,
    output logic [31:0]      fetch_addr,
    output logic             brownout_detector_irq,
    output logic             swd_enable,
    output logic             jtag_bscan_enable,
    output logic             in_system_programming_en,
    output logic             programming_entry_pin_en,
    output logic             isp_limited_cmds,
    output logic             isp_full_erase_only,
    output logic             sector0_write_en,
    output logic             in_application_programming_en,
    output logic [1:0]       code_read_protection
);

    rst_dbg_pkg::state_s q, d;

    logic       pin_rst;
    logic       bod_rst;
    logic       any_rst;
    logic       wr_fire;
    logic [1:0] lvl_new;
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        d.fetch_go = 1'b0;
        // write fires once address and data are both held
        wr_fire = q.aw_got & q.w_got & ~q.bvalid;

        // pin filter: low long enough counts as reset
        if (reset_pin_n) begin
            d.pin_cnt = 4'h0;
        end else if (q.pin_cnt < 4'(rst_dbg_pkg::PIN_MIN_CYC)) begin
            d.pin_cnt = q.pin_cnt + 4'h1;
        end
        pin_rst = (d.pin_cnt >= 4'(rst_dbg_pkg::PIN_MIN_CYC));
        bod_rst = q.ctrl[rst_dbg_pkg::CTRL_RST_EN]
                & bod_rst_below[q.ctrl[rst_dbg_pkg::CTRL_RST_SEL +: 2]];
        any_rst = pin_rst | watchdog_reset | power_on_reset | bod_rst;

        // protection decode from flash pattern
        if (flash_prot_word == PROT_THREE_PATTERN) begin
            lvl_new = rst_dbg_pkg::LVL_THREE;
        end else if (flash_prot_word == PROT_TWO_PATTERN) begin
            lvl_new = rst_dbg_pkg::LVL_TWO;
        end else if (flash_prot_word == PROT_ONE_PATTERN) begin
            lvl_new = rst_dbg_pkg::LVL_ONE;
        end else begin
            lvl_new = rst_dbg_pkg::LVL_NONE;
        end

        // cause flags: set wins over clear
        if (wr_fire && q.awaddr == rst_dbg_pkg::CAUSE_OFF && q.wstrb0) begin
            d.cause = q.cause & ~q.wdata[3:0];
        end
        d.cause[rst_dbg_pkg::CAUSE_PIN] = d.cause[rst_dbg_pkg::CAUSE_PIN] | pin_rst;
        d.cause[rst_dbg_pkg::CAUSE_WDT] = d.cause[rst_dbg_pkg::CAUSE_WDT] | watchdog_reset;
        d.cause[rst_dbg_pkg::CAUSE_POR] = d.cause[rst_dbg_pkg::CAUSE_POR] | power_on_reset;
        d.cause[rst_dbg_pkg::CAUSE_BOD] = d.cause[rst_dbg_pkg::CAUSE_BOD] | bod_rst;

        // reset sequencer
        unique case (q.st)
            rst_dbg_pkg::ST_HOLD: begin
                d.chip_rst = 1'b1;
                if (any_rst) begin
                    d.hold_cnt = 4'h0;
                end else if (q.hold_cnt == 4'(rst_dbg_pkg::HOLD_CYC - 1)) begin
                    d.st = rst_dbg_pkg::ST_RUN;
                    d.chip_rst = 1'b0;
                    d.fetch_go = 1'b1;
                    d.fetch_addr = rst_dbg_pkg::BOOT_ADDR;
                    d.lvl = lvl_new;
                end else begin
                    d.hold_cnt = q.hold_cnt + 4'h1;
                end
            end
            rst_dbg_pkg::ST_RUN: begin
                if (any_rst) begin
                    d.st = rst_dbg_pkg::ST_HOLD;
                    d.chip_rst = 1'b1;
                    d.hold_cnt = 4'h0;
                end
            end
        endcase

        // ctrl and clock select return to defaults while chip reset holds
        if (d.chip_rst) begin
            d.ctrl = rst_dbg_pkg::CTRL_RESET;
            d.main_clk_irc = 1'b1;
        end else begin
            d.main_clk_irc = ~q.ctrl[rst_dbg_pkg::CTRL_CLK_EXT];
        end

        d.bod_irq = bod_irq_below[q.ctrl[rst_dbg_pkg::CTRL_IRQ_SEL +: 2]];
        d.jtag_en = ~reset_pin_n;
        d.swd_en = reset_pin_n & ~d.chip_rst
                 & (d.lvl == rst_dbg_pkg::LVL_NONE);
        d.isp_en = (d.lvl != rst_dbg_pkg::LVL_THREE);
        d.isp_pin_en = d.isp_en & ~q.ctrl[rst_dbg_pkg::CTRL_ISP_DIS];

        ////////////////////////////////////////////////////////////////////
        // axi4-lite write channel
        if (s_axi_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata[7:0];
            d.wstrb0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = rst_dbg_pkg::RESP_OKAY;
            unique case (q.awaddr)
                rst_dbg_pkg::CTRL_OFF: begin
                    if (q.wstrb0 && !d.chip_rst) begin
                        d.ctrl = q.wdata[6:0];
                    end
                end
                rst_dbg_pkg::STATUS_OFF, rst_dbg_pkg::CAUSE_OFF: begin
                end
                default: d.bresp = rst_dbg_pkg::RESP_SLVERR;
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        d.awready = ~d.aw_got & ~d.bvalid;
        d.wready = ~d.w_got & ~d.bvalid;

        // axi4-lite read channel
        rd_val = 32'h0000_0000;
        rd_val[rst_dbg_pkg::STAT_BOD_IRQ] = q.bod_irq;
        rd_val[rst_dbg_pkg::STAT_LEVEL +: 2] = q.lvl;
        rd_val[rst_dbg_pkg::STAT_SWD] = q.swd_en;
        rd_val[rst_dbg_pkg::STAT_JTAG] = q.jtag_en;
        rd_val[rst_dbg_pkg::STAT_CLK_IRC] = q.main_clk_irc;
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = rst_dbg_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                rst_dbg_pkg::CTRL_OFF:   d.rdata = {25'h0, q.ctrl};
                rst_dbg_pkg::STATUS_OFF: d.rdata = rd_val;
                rst_dbg_pkg::CAUSE_OFF:  d.rdata = {28'h0, q.cause};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = rst_dbg_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        d.arready = ~d.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.st <= rst_dbg_pkg::ST_HOLD;
            q.chip_rst <= 1'b1;
            q.main_clk_irc <= 1'b1;
            q.lvl <= rst_dbg_pkg::LVL_THREE;
            q.cause <= rst_dbg_pkg::CAUSE_RESET;
            q.ctrl <= rst_dbg_pkg::CTRL_RESET;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign chip_reset_n = ~q.chip_rst;
    assign internal_rc_oscillator_en = q.main_clk_irc | q.chip_rst;
    assign main_clk_is_irc = q.main_clk_irc;
    assign flash_ctrl_init = q.chip_rst;
    assign fetch_start = q.fetch_go;
    assign fetch_addr = q.fetch_addr;
    assign brownout_detector_irq = q.bod_irq;
    assign swd_enable = q.swd_en;
    assign jtag_bscan_enable = q.jtag_en;
    assign in_system_programming_en = q.isp_en;
    assign programming_entry_pin_en = q.isp_pin_en;
    assign isp_limited_cmds = (q.lvl == rst_dbg_pkg::LVL_ONE);
    assign isp_full_erase_only = (q.lvl == rst_dbg_pkg::LVL_TWO);
    assign sector0_write_en = (q.lvl != rst_dbg_pkg::LVL_ONE) & q.isp_en;
    assign in_application_programming_en = ~q.chip_rst;
    assign code_read_protection = q.lvl;

endmodule // reset_and_debug_access_control

`default_nettype wire

// >>> inc/rst_dbg_pkg.sv
package rst_dbg_pkg;
    // register byte offsets
    localparam logic [3:0]  CTRL_OFF   = 4'h0;
    localparam logic [3:0]  STATUS_OFF = 4'h4;
    localparam logic [3:0]  CAUSE_OFF  = 4'h8;
    // ctrl fields
    localparam int CTRL_IRQ_SEL  = 0;
    localparam int CTRL_RST_SEL  = 2;
    localparam int CTRL_ISP_DIS  = 4;
    localparam int CTRL_CLK_EXT  = 5;
    localparam int CTRL_RST_EN   = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // status fields
    localparam int STAT_BOD_IRQ  = 0;
    localparam int STAT_LEVEL    = 4;
    localparam int STAT_SWD      = 8;
    localparam int STAT_JTAG     = 9;
    localparam int STAT_CLK_IRC  = 10;
    // cause bits: pin, watchdog, power-on, brownout
    localparam int CAUSE_PIN = 0;
    localparam int CAUSE_WDT = 1;
    localparam int CAUSE_POR = 2;
    localparam int CAUSE_BOD = 3;
    localparam logic [3:0] CAUSE_RESET = 4'h4;
    // protection levels
    localparam logic [1:0] LVL_NONE  = 2'h0;
    localparam logic [1:0] LVL_ONE   = 2'h1;
    localparam logic [1:0] LVL_TWO   = 2'h2;
    localparam logic [1:0] LVL_THREE = 2'h3;
    localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
    // timing
    localparam int CLK_PERIOD_PS  = 20000;
    localparam int PIN_MIN_NS     = 50;
    localparam int PIN_MIN_CYC    = (PIN_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_CYC       = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b10
    } seq_e;

    typedef struct packed {
        seq_e        st;
        logic [3:0]  pin_cnt;
        logic [3:0]  hold_cnt;
        logic        chip_rst;
        logic        fetch_go;
        logic [31:0] fetch_addr;
        logic [1:0]  lvl;
        logic        bod_irq;
        logic        swd_en;
        logic        jtag_en;
        logic        isp_en;
        logic        isp_pin_en;
        logic        main_clk_irc;
        logic [3:0]  cause;
        logic [6:0]  ctrl;
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  awaddr;
        logic [7:0]  wdata;
        logic        wstrb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_s;
endpackage

// >>> test/rst_dbg_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rst_dbg_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        reset_pin_n,
    input wire logic        watchdog_reset,
    input wire logic        power_on_reset,
    input wire logic        chip_reset_n,
    input wire logic        internal_rc_oscillator_en,
    input wire logic        flash_ctrl_init,
    input wire logic        fetch_start,
    input wire logic [31:0] fetch_addr,
    input wire logic        swd_enable,
    input wire logic        in_system_programming_en,
    input wire logic        programming_entry_pin_en,
    input wire logic        isp_limited_cmds,
    input wire logic        sector0_write_en,
    input wire logic [1:0]  code_read_protection
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_src_reset: assert property ((watchdog_reset || power_on_reset) |=> !chip_reset_n [*8])
        else $error("chip reset not held after source");
    chk_pin_reset: assert property (!reset_pin_n [*3] |=> !chip_reset_n)
        else $error("pin low three cycles without reset");
    chk_osc_flash: assert property (!chip_reset_n |-> internal_rc_oscillator_en && flash_ctrl_init)
        else $error("oscillator or flash init missing in reset");
    chk_fetch_boot: assert property ($rose(chip_reset_n) |-> fetch_start && fetch_addr == 32'h0)
        else $error("no fetch at zero on release");
    chk_swd_gate: assert property (swd_enable |-> chip_reset_n && code_read_protection == 2'h0)
        else $error("debug open while blocked");
    chk_lvl_three: assert property (code_read_protection == 2'h3 |-> !in_system_programming_en && !programming_entry_pin_en)
        else $error("programming open at level three");
    chk_lvl_one: assert property (code_read_protection == 2'h1 |-> isp_limited_cmds && !sector0_write_en)
        else $error("level one programming not limited");
    chk_lvl_held: assert property (chip_reset_n && $past(chip_reset_n) |-> $stable(code_read_protection))
        else $error("protection level changed while running");
    ////////////////////////////////////////
    cov_release: cover property ($rose(chip_reset_n));
    cov_lvl_three: cover property (code_read_protection == 2'h3);
    cov_pin: cover property (!reset_pin_n [*3]);
endmodule // rst_dbg_asserts
bind reset_and_debug_access_control rst_dbg_asserts chk_u (
    .aclk, .aresetn, .reset_pin_n, .watchdog_reset, .power_on_reset, .chip_reset_n,
    .internal_rc_oscillator_en, .flash_ctrl_init, .fetch_start, .fetch_addr, .swd_enable,
    .in_system_programming_en, .programming_entry_pin_en, .isp_limited_cmds,
    .sector0_write_en, .code_read_protection
);
`default_nettype wire

// >>> test/rst_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
module rst_pin_drv (
    input  wire logic       aclk,
    input  wire logic [3:0] low_len,
    output var  logic       reset_pin_n
);
    int left = 0;
    initial reset_pin_n = 1'h1;
    ////////////////////////////////////////
    always @(posedge aclk) begin
        if (low_len != 4'h0) begin
            reset_pin_n <= 1'h0;
            left        <= low_len - 1;
        end else if (left > 0) begin
            left <= left - 1;
        end else begin
            reset_pin_n <= 1'h1;
        end
    end
endmodule // rst_pin_drv
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [31:0] P1 = 32'hA5C3_0F01;
    localparam logic [31:0] P2 = 32'h5A3C_F002;
    localparam logic [31:0] P3 = 32'hC3A5_0F03;
    logic        aclk, aresetn, watchdog_reset, power_on_reset, reset_pin_n, fetch_start;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        chip_reset_n, brownout_detector_irq, swd_enable, main_clk_is_irc;
    logic        jtag_bscan_enable, in_system_programming_en, programming_entry_pin_en;
    logic        isp_limited_cmds, isp_full_erase_only, sector0_write_en, iap_en;
    logic [1:0]  s_axi_bresp, s_axi_rresp, code_read_protection, resp;
    logic [3:0]  bod_irq_below, bod_rst_below, s_axi_awaddr, s_axi_araddr, s_axi_wstrb, pin_len;
    logic [31:0] flash_prot_word, s_axi_wdata, s_axi_rdata, fetch_addr, rdat, seed, v;
    logic [31:0] pats [4];
    int          mismatches = 0, tests_run = 0, m_cause = 4;
    rst_pin_drv pin_u (.aclk, .low_len(pin_len), .reset_pin_n);
    reset_and_debug_access_control #(.PROT_ONE_PATTERN(P1), .PROT_TWO_PATTERN(P2),
        .PROT_THREE_PATTERN(P3)) dut_u (
        .aclk, .aresetn, .reset_pin_n, .watchdog_reset, .power_on_reset, .bod_irq_below,
        .bod_rst_below, .flash_prot_word, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_reset_n, .fetch_start, .fetch_addr,
        .internal_rc_oscillator_en(), .main_clk_is_irc, .flash_ctrl_init(), .swd_enable,
        .brownout_detector_irq, .jtag_bscan_enable, .in_system_programming_en,
        .programming_entry_pin_en, .isp_limited_cmds, .isp_full_erase_only,
        .sector0_write_en, .in_application_programming_en(iap_en), .code_read_protection);
    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        resp = s_axi_bresp;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    task automatic wait_up();
        repeat (2) @(posedge aclk);
        for (int n = 0; n < 60 && !chip_reset_n; n++) @(posedge aclk);
        cmp(chip_reset_n, 1'h1);
    endtask
    task automatic pin_pulse(input logic [3:0] len);
        pin_len <= len;
        @(posedge aclk);
        pin_len <= 4'h0;
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        seed = 32'h2495d5f1;
        {aresetn, watchdog_reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, bod_irq_below, bod_rst_below, pin_len, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb, power_on_reset} = {32'h0, 4'h1, 1'h1};
        flash_prot_word = $random(seed);
        pats = '{flash_prot_word, P1, P2, P3};
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        power_on_reset <= 1'h0;
        wait_up();
        cmp(fetch_addr, 32'h0);
        cmp(iap_en, 1'h1);
        rd(rst_dbg_pkg::CTRL_OFF);
        cmp(rdat, 32'h0);
        rd(4'hC);
        cmp(resp, rst_dbg_pkg::RESP_SLVERR);
        pin_pulse(4'h2);
        repeat (6) @(posedge aclk);
        cmp(chip_reset_n, 1'h1);
        cmp(swd_enable, 1'h1);
        pin_pulse(4'h4);
        repeat (5) @(posedge aclk);
        cmp(chip_reset_n, 1'h0);
        cmp(jtag_bscan_enable, 1'h1);
        cmp(swd_enable, 1'h0);
        cmp(iap_en, 1'h0);
        m_cause = m_cause | 1;
        wait_up();
        cmp(jtag_bscan_enable, 1'h0);
        for (int i = 0; i < 4; i++) begin
            flash_prot_word <= pats[i];
            watchdog_reset <= 1'h1;
            @(posedge aclk);
            watchdog_reset <= 1'h0;
            m_cause = m_cause | 2;
            wait_up();
            cmp(code_read_protection, i);
            cmp(swd_enable, i == 0);
            cmp(isp_limited_cmds, i == 1);
            cmp(isp_full_erase_only, i == 2);
            cmp(sector0_write_en, i % 2 == 0);
            cmp(in_system_programming_en, i != 3);
            cmp(main_clk_is_irc, 1'h1);
            rd(rst_dbg_pkg::STATUS_OFF);
            cmp(rdat[5:4], i);
            axw(rst_dbg_pkg::CTRL_OFF, 32'h30);
            cmp(programming_entry_pin_en, 1'h0);
            cmp(main_clk_is_irc, 1'h0);
        end
        flash_prot_word <= P1;
        for (int k = 0; k < 8; k++) begin
            v = $random(seed);
            axw(rst_dbg_pkg::CTRL_OFF, k % 4);
            bod_irq_below <= v[3:0];
            repeat (3) @(posedge aclk);
            cmp(brownout_detector_irq, v[k % 4]);
            rd(rst_dbg_pkg::STATUS_OFF);
            cmp(rdat[0], v[k % 4]);
        end
        cmp(code_read_protection, 3);
        axw(rst_dbg_pkg::CTRL_OFF, 32'h48);
        bod_rst_below <= 4'hB;
        repeat (6) @(posedge aclk);
        cmp(chip_reset_n, 1'h1);
        bod_rst_below <= 4'h4;
        repeat (3) @(posedge aclk);
        cmp(chip_reset_n, 1'h0);
        bod_rst_below <= 4'h0;
        m_cause = m_cause | 8;
        wait_up();
        rd(rst_dbg_pkg::CAUSE_OFF);
        cmp(rdat, m_cause);
        axw(rst_dbg_pkg::CAUSE_OFF, 32'h5);
        cmp(resp, rst_dbg_pkg::RESP_OKAY);
        rd(rst_dbg_pkg::CAUSE_OFF);
        cmp(rdat, 32'hA);
        axw(4'hC, 32'h0);
        cmp(resp, rst_dbg_pkg::RESP_SLVERR);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
